// ### rtl/tbpc_timer_unit.sv
// Two timer blocks, each with a block prescaler, a core timer and an auxiliary timer.
// Assumes a 100 MHz system clock and an Avalon-MM master that holds requests.
`include "tbpc_map.svh"
`timescale 1ns/1ps
`default_nettype none

module tbpc_timer_unit #(
    parameter int W = 16
) (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic [7:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    output logic             irq_o
);

    // ========================================================================
    // Reset release
    // ========================================================================
    logic rst_s1_q;
    logic rst_n;

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rst_s1_q <= 1'b0;
            rst_n    <= 1'b0;
        end
        else
        begin
            rst_s1_q <= 1'b1;
            rst_n    <= rst_s1_q;
        end
    end

    // ========================================================================
    // Bus slave
    // ========================================================================
    // One wait state per access gives a registered read path without a mux chain.
    logic ack_q;
    logic wr_en;
    logic [31:0] rdata_d;
    logic [31:0] rdata_q;

    assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_q;
    assign wr_en             = avs_write_i & ack_q;
    assign avs_readdata_o    = rdata_q;

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
            ack_q <= 1'b0;
        else
            ack_q <= (avs_read_i | avs_write_i) & ~ack_q;
    end

    logic [`TBPC_CTRL_BITS-1:0] ctrl_q [2];
    logic [W-1:0]               core_q [2];
    logic [W-1:0]               aux_q  [2];
    logic [3:0]                 stat_q;
    logic [3:0]                 en_q;

    always_comb
    begin
        rdata_d = 32'h0000_0000;
        case (avs_address_i)
            `TBPC_OFS_CTRL_ONE: rdata_d[`TBPC_CTRL_BITS-1:0] = ctrl_q[0];
            `TBPC_OFS_CORE_ONE: rdata_d[W-1:0] = core_q[0];
            `TBPC_OFS_AUX_ONE:  rdata_d[W-1:0] = aux_q[0];
            `TBPC_OFS_CTRL_TWO: rdata_d[`TBPC_CTRL_BITS-1:0] = ctrl_q[1];
            `TBPC_OFS_CORE_TWO: rdata_d[W-1:0] = core_q[1];
            `TBPC_OFS_AUX_TWO:  rdata_d[W-1:0] = aux_q[1];
            `TBPC_OFS_IRQ_STAT: rdata_d[3:0] = stat_q;
            `TBPC_OFS_IRQ_EN:   rdata_d[3:0] = en_q;
            default:            rdata_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
            rdata_q <= 32'h0000_0000;
        else if (avs_read_i & ~ack_q)
            rdata_q <= rdata_d;
    end

    // ========================================================================
    // Block prescalers and individual prescalers
    // ========================================================================
    logic [5:0] per      [2];
    logic [5:0] bcnt_q   [2];
    logic       btick    [2];
    logic [6:0] icnt_q   [2];
    logic       core_tk  [2];
    logic       aux_tk   [2];
    logic       core_cy  [2];
    logic       aux_cy   [2];
    logic       aux_step [2];

    function automatic logic [6:0] ind_mask(input tbpc_pkg::tbpc_ind_t sel);
        ind_mask = 7'(({7'h00, 1'b1} << sel) - 8'h01);
    endfunction

    always_comb
    begin
        case (tbpc_pkg::tbpc_bps_e'(ctrl_q[0][`TBPC_F_BPS_LSB +: 2]))
            tbpc_pkg::TBPC_BPS_FAST: per[0] = `TBPC_B1_PER_01;
            tbpc_pkg::TBPC_BPS_DEF:  per[0] = `TBPC_B1_PER_00;
            tbpc_pkg::TBPC_BPS_MID:  per[0] = `TBPC_B1_PER_11;
            default:                 per[0] = `TBPC_B1_PER_10;
        endcase
        case (tbpc_pkg::tbpc_bps_e'(ctrl_q[1][`TBPC_F_BPS_LSB +: 2]))
            tbpc_pkg::TBPC_BPS_FAST: per[1] = `TBPC_B2_PER_01;
            tbpc_pkg::TBPC_BPS_DEF:  per[1] = `TBPC_B2_PER_00;
            tbpc_pkg::TBPC_BPS_MID:  per[1] = `TBPC_B2_PER_11;
            default:                 per[1] = `TBPC_B2_PER_10;
        endcase
    end

    // A prescaler change takes effect at once; a counter beyond the new period
    // restarts, which software covers by reinitialising the block afterwards.
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int b = 0; b < 2; b++)
            begin
                bcnt_q[b] <= 6'h00;
                icnt_q[b] <= 7'h00;
            end
        end
        else
        begin
            for (int b = 0; b < 2; b++)
            begin
                bcnt_q[b] <= btick[b] ? 6'h00 : 6'(bcnt_q[b] + 6'h01);
                if (btick[b])
                    icnt_q[b] <= 7'(icnt_q[b] + 7'h01);
            end
        end
    end

    generate
        for (genvar g = 0; g < 2; g++)
        begin : g_blk
            logic [6:0] cmask;
            logic [6:0] amask;
            logic       concat;
            logic       adn;
            assign btick[g]  = (bcnt_q[g] >= 6'(per[g] - 6'h01));
            assign cmask     = ind_mask(ctrl_q[g][`TBPC_F_CORE_IND_LSB +: 3]);
            assign amask     = ind_mask(ctrl_q[g][`TBPC_F_AUX_IND_LSB +: 3]);
            assign concat    = ctrl_q[g][`TBPC_F_CONCAT];
            assign core_tk[g] = btick[g] & ctrl_q[g][`TBPC_F_CORE_RUN]
                              & ((icnt_q[g] & cmask) == cmask);
            assign aux_tk[g]  = btick[g] & ctrl_q[g][`TBPC_F_AUX_RUN]
                              & ((icnt_q[g] & amask) == amask);
            assign core_cy[g] = core_tk[g] & (ctrl_q[g][`TBPC_F_CORE_DOWN]
                              ? (core_q[g] == '0) : (core_q[g] == '1));
            // In concatenation the auxiliary follows the core carry only.
            assign aux_step[g] = concat ? core_cy[g] : aux_tk[g];
            // A local copy of the direction keeps this net sensitive to control writes.
            assign adn         = concat ? ctrl_q[g][`TBPC_F_CORE_DOWN]
                                        : ctrl_q[g][`TBPC_F_AUX_DOWN];
            assign aux_cy[g]   = aux_step[g] & (adn ? (aux_q[g] == '0) : (aux_q[g] == '1));
        end
    endgenerate

    function automatic logic aux_dn(input int b);
        aux_dn = ctrl_q[b][`TBPC_F_CONCAT] ? ctrl_q[b][`TBPC_F_CORE_DOWN]
                                           : ctrl_q[b][`TBPC_F_AUX_DOWN];
    endfunction

    // ========================================================================
    // Control registers
    // ========================================================================
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_q[0] <= `TBPC_CTRL_RESET;
            ctrl_q[1] <= `TBPC_CTRL_RESET;
        end
        else if (wr_en)
        begin
            if (avs_address_i == `TBPC_OFS_CTRL_ONE)
                ctrl_q[0] <= avs_writedata_i[`TBPC_CTRL_BITS-1:0];
            if (avs_address_i == `TBPC_OFS_CTRL_TWO)
                ctrl_q[1] <= avs_writedata_i[`TBPC_CTRL_BITS-1:0];
        end
    end

    // ========================================================================
    // Timers
    // ========================================================================
    // A software load wins over a count in the same cycle.
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int b = 0; b < 2; b++)
            begin
                core_q[b] <= '0;
                aux_q[b]  <= '0;
            end
        end
        else
        begin
            for (int b = 0; b < 2; b++)
            begin
                if (wr_en && avs_address_i == (b == 0 ? `TBPC_OFS_CORE_ONE : `TBPC_OFS_CORE_TWO))
                    core_q[b] <= avs_writedata_i[W-1:0];
                else if (core_tk[b])
                    core_q[b] <= ctrl_q[b][`TBPC_F_CORE_DOWN] ? W'(core_q[b] - 1'b1)
                                                              : W'(core_q[b] + 1'b1);
                if (wr_en && avs_address_i == (b == 0 ? `TBPC_OFS_AUX_ONE : `TBPC_OFS_AUX_TWO))
                    aux_q[b] <= avs_writedata_i[W-1:0];
                else if (aux_step[b])
                    aux_q[b] <= aux_dn(b) ? W'(aux_q[b] - 1'b1)
                                          : W'(aux_q[b] + 1'b1);
            end
        end
    end

    // ========================================================================
    // Interrupts
    // ========================================================================
    logic [3:0] ev;
    assign ev = {aux_cy[1], core_cy[1], aux_cy[0], core_cy[0]};

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
            stat_q <= 4'h0;
        else if (wr_en && avs_address_i == `TBPC_OFS_IRQ_CLR)
            stat_q <= (stat_q & ~avs_writedata_i[3:0]) | ev;
        else
            stat_q <= stat_q | ev;
    end

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
            en_q <= 4'h0;
        else if (wr_en && avs_address_i == `TBPC_OFS_IRQ_EN)
            en_q <= avs_writedata_i[3:0];
    end

    assign irq_o = |(stat_q & en_q);

endmodule

`default_nettype wire

// ### common/tbpc_map.svh
// Register offsets, field positions, reset values and prescale counts of the timer unit.
// Assumes an 8-bit Avalon-MM byte address presented by the bus fabric.
`ifndef TBPC_MAP_SVH
`define TBPC_MAP_SVH

// ============================================================================
// Register byte offsets
// ============================================================================
`define TBPC_OFS_CTRL_ONE   8'h00
`define TBPC_OFS_CORE_ONE   8'h04
`define TBPC_OFS_AUX_ONE    8'h08
`define TBPC_OFS_CTRL_TWO   8'h0C
`define TBPC_OFS_CORE_TWO   8'h10
`define TBPC_OFS_AUX_TWO    8'h14
`define TBPC_OFS_IRQ_STAT   8'h18
`define TBPC_OFS_IRQ_CLR    8'h1C
`define TBPC_OFS_IRQ_EN     8'h20

// ============================================================================
// Control register fields
// ============================================================================
`define TBPC_F_BPS_LSB      0
`define TBPC_F_CORE_IND_LSB 2
`define TBPC_F_CORE_RUN     5
`define TBPC_F_CORE_DOWN    6
`define TBPC_F_AUX_IND_LSB  7
`define TBPC_F_AUX_RUN      10
`define TBPC_F_AUX_DOWN     11
`define TBPC_F_CONCAT       12
`define TBPC_CTRL_BITS      13
`define TBPC_CTRL_RESET     13'h0000

// ============================================================================
// Basic clock periods in system clocks (half the two-cycle span)
// ============================================================================
`define TBPC_B1_PER_01      6'h04
`define TBPC_B1_PER_00      6'h08
`define TBPC_B1_PER_11      6'h10
`define TBPC_B1_PER_10      6'h20
`define TBPC_B2_PER_01      6'h02
`define TBPC_B2_PER_00      6'h04
`define TBPC_B2_PER_11      6'h08
`define TBPC_B2_PER_10      6'h10

`endif

// ### common/tbpc_pkg.sv
// Types shared by the timer unit.
// Assumes the map header supplies all numeric constants except the prescale select codes defined here.
package tbpc_pkg;
    typedef enum logic [1:0]
    {
        TBPC_BPS_DEF  = 2'b00,
        TBPC_BPS_FAST = 2'b01,
        TBPC_BPS_SLOW = 2'b10,
        TBPC_BPS_MID  = 2'b11
    } tbpc_bps_e;
    typedef logic [2:0] tbpc_ind_t;
endpackage

// ### verif/tbpc_timer_unit_properties.sv
// Checker of the timer unit's bus ports, with a cover of its interrupt output.
// Assumes it is bound to tbpc_timer_unit and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
// ============================================================================
// Checker
// ============================================================================
module tbpc_props (
    input wire logic        clk_i,
    input wire logic        rst_n_i,
    input wire logic [7:0]  avs_address_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic        avs_waitrequest_o,
    input wire logic        irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    wire logic req = avs_read_i | avs_write_i;
    wire logic rack = avs_read_i & ~avs_waitrequest_o;
    a_wait_first: assert property (req && !$past(req) |-> avs_waitrequest_o)
        else $error("no wait state on a new access");
    a_wait_once: assert property (req && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("second wait state");
    a_ready_after: assert property (req && !avs_waitrequest_o |-> $past(avs_waitrequest_o))
        else $error("access answered without wait state");
    a_idle_ready: assert property (!req |-> !avs_waitrequest_o)
        else $error("wait while idle");
    a_data_hold: assert property (!avs_read_i |=> $stable(avs_readdata_o))
        else $error("read data moved without a read");
    a_timer_width: assert property (rack && avs_address_i inside {8'h04, 8'h08, 8'h10,
        8'h14} |-> avs_readdata_o[31:16] == 16'h0000)
        else $error("timer upper bits set");
    a_ctrl_width: assert property (rack && avs_address_i inside {8'h00, 8'h0C}
        |-> avs_readdata_o[31:13] == 19'h00000)
        else $error("control upper bits set");
    cover property (avs_write_i && !avs_waitrequest_o);
    cover property (rack && avs_address_i == 8'h08);
    cover property (irq_o);
endmodule
bind tbpc_timer_unit tbpc_props u_props (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .irq_o(irq_o));
`default_nettype wire

// ### verif/tb_top.sv
// Self-checking bench of the timer unit: reset values, rates, concatenation, interrupts.
// Assumes the bus contract of one wait state and the register map of the map header.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        clk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic [7:0]  avs_address_i = 8'h00;
    logic        avs_read_i = 1'b0;
    logic        avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h00000000;
    logic [31:0] avs_readdata_o;
    logic        avs_waitrequest_o;
    logic        irq_o;
    int          failures = 0;
    int          num_checks = 0;
    int          cycles = 0;
    logic [15:0] seed = 16'h002A;
    logic [31:0] q, a, b, h1, h2;
    logic [15:0] e;
    logic        dn;
    int          p, ind, k;
    logic [7:0]  regs [10] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C,
                               8'h20, 8'h24};
    logic [15:0] rows [3][4] = '{'{16'hFFF8, 16'h0005, 16'h1021, 16'h0006},
                                 '{16'h0002, 16'h0005, 16'h1061, 16'h0004},
                                 '{16'hFFFE, 16'hFFFF, 16'h1021, 16'h0000}};
    logic [3:0]  stat [3] = '{4'h1, 4'h1, 4'h3};

    tbpc_timer_unit #(.W(16)) u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .irq_o(irq_o));

    // ========================================================================
    // Clock, timeout and helpers
    // ========================================================================
    initial forever #5 clk_i = ~clk_i;
    always @(posedge clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 40000)
        begin
            failures = failures + 1;
            stop_test();
        end
    end
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic chk(input string n, input logic [31:0] ex, input logic [31:0] got);
        num_checks++;
        if (got !== ex)
        begin
            failures++;
            $display("Error %s expected %h seen %h", n, ex, got);
        end
    endtask
    // The request stands until the rising edge that sees waitrequest low; one idle edge
    // follows so that a second call never reassigns a strobe in the same time step.
    task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
        avs_address_i <= ad;
        avs_writedata_i <= d;
        avs_write_i <= w;
        avs_read_i <= ~w;
        do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
        q = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic stop_test();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // ========================================================================
    // Main sequence
    // ========================================================================
    initial
    begin
        repeat (8) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        bus(1'b1, 8'h24, 32'hFFFFFFFF);
        bus(1'b1, 8'h18, 32'h0000000F);
        foreach (regs[i])
        begin
            bus(1'b0, regs[i], 32'h0);
            chk("reset value", 32'h0, q);
        end
        $display("test reset done");
        // A read takes three cycles here, so the samples are k cycles apart.
        for (int n = 0; n < 8; n++)
        begin
            seed = lfsr(seed);
            ind = seed[1:0];
            dn = seed[2];
            p = (n % 4 == 1 ? 4 : n % 4 == 0 ? 8 : n % 4 == 3 ? 16 : 32) >> (n / 4);
            k = (8 * p) << ind;
            bus(1'b1, n < 4 ? 8'h04 : 8'h10, {16'h0, lfsr(seed)});
            bus(1'b1, n < 4 ? 8'h00 : 8'h0C, (n % 4) | (ind << 2) | 32'h20 | (dn << 6));
            bus(1'b0, n < 4 ? 8'h04 : 8'h10, 32'h0);
            a = q;
            repeat (k - 3) @(posedge clk_i);
            bus(1'b0, n < 4 ? 8'h04 : 8'h10, 32'h0);
            e = dn ? a[15:0] - 16'(k / (p << ind)) : a[15:0] + 16'(k / (p << ind));
            chk("rate", {16'h0, e}, q);
            bus(1'b1, n < 4 ? 8'h00 : 8'h0C, 32'h0);
        end
        $display("test rates done");
        for (int r = 0; r < 3; r++)
        begin
            bus(1'b1, 8'h1C, 32'hF);
            bus(1'b1, 8'h04, {16'h0, rows[r][0]});
            bus(1'b1, 8'h08, {16'h0, rows[r][1]});
            bus(1'b1, 8'h20, 32'hF);
            bus(1'b1, 8'h00, {16'h0, rows[r][2]});
            bus(1'b0, 8'h08, 32'h0);
            chk("aux before wrap", {16'h0, rows[r][1]}, q);
            repeat (64) @(posedge clk_i);
            bus(1'b0, 8'h08, 32'h0);
            h1 = q;
            bus(1'b0, 8'h04, 32'h0);
            repeat (8) @(posedge clk_i);
            bus(1'b0, 8'h08, 32'h0);
            h2 = q;
            if (h1 !== h2)
                bus(1'b0, 8'h04, 32'h0);
            chk("aux high part", {16'h0, rows[r][3]}, h2);
            bus(1'b0, 8'h18, 32'h0);
            chk("status", {28'h0, stat[r]}, q);
            chk("irq raised", 32'h1, {31'h0, irq_o});
            bus(1'b1, 8'h20, 32'h0);
            chk("irq masked", 32'h0, {31'h0, irq_o});
            bus(1'b1, 8'h1C, 32'hF);
            bus(1'b0, 8'h18, 32'h0);
            chk("status cleared", 32'h0, q);
            bus(1'b1, 8'h00, 32'h0);
        end
        $display("test concatenation done");
        stop_test();
    end
endmodule
`default_nettype wire
